/* File: core/pattern_cfg.svh */
`ifndef PATTERN_CFG_SVH
`define PATTERN_CFG_SVH

// Register word indices; the APB byte address is the index times four
`define IDX_TRIG_SEL 8'hA1
`define IDX_NDE_HIGH 8'hA2
`define IDX_NDE_LOW 8'hA3
`define IDX_ND_HIGH_EVEN 8'hA4
`define IDX_ND_LOW_EVEN 8'hA5
`define IDX_ND_HIGH_ODD 8'hA6
`define IDX_ND_LOW_ODD 8'hA7
`define IDX_PORT_STATE 8'hB0

// Reset values
`define RST_TRIG_SEL 8'hFF
`define RST_NDE 8'h00
`define RST_ND 8'h00
`define RST_ND_NIB 4'h0

// Field positions in the trigger select register
`define GRP0_SEL_LSB 0
`define GRP1_SEL_LSB 2
`define GRP2_SEL_LSB 4
`define GRP3_SEL_LSB 6

`endif

/* File: core/pattern_pkg.sv */
package pattern_pkg;
  typedef logic [1:0] chan_sel_t;
  typedef struct packed {
    logic [3:0] match_a;
  } timer_events_s;
  typedef struct packed {
    logic [7:0] port_a;
    logic [3:0] port_b;
  } pattern_pins_s;
endpackage

/* File: core/group_latch.sv */
`timescale 1ns/100ps
module group_latch #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Trigger selection
  input wire logic [1:0] sel,
  input wire logic [3:0] match_a,
  // Data
  input wire logic [W-1:0] staged,
  input wire logic [W-1:0] enable,
  output logic [W-1:0] pins_r
);
  wire fire;
  assign fire = match_a[sel];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_r <= '0;
    end else if (fire) begin
      // Disabled bits keep their last value
      pins_r <= (staged & enable) | (pins_r & ~enable);
    end
  end
endmodule

/* File: core/pattern_output_trigger_select.sv */
`timescale 1ns/100ps
`include "pattern_cfg.svh"
module pattern_output_trigger_select
  import pattern_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer compare match A events
  input wire timer_events_s timer_events,
  // Pattern pins
  output pattern_pins_s pins
);
  logic [7:0] trig_sel_r;
  logic [7:0] nde_high_r;
  logic [7:0] nde_low_r;
  logic [7:0] nd_low_r;
  logic [3:0] nd_high_r;
  logic [3:0] nd_a4_upper_r;
  logic [7:0] port_a_r;
  logic [3:0] port_b_r;
  logic [7:0] trig_sel_nxt;
  logic [7:0] nde_high_nxt;
  logic [7:0] nde_low_nxt;
  logic [7:0] nd_low_nxt;
  logic [3:0] nd_high_nxt;
  logic [3:0] nd_a4_upper_nxt;
  logic [3:0] grp0_pins_r;
  logic [3:0] grp1_pins_r;
  logic [3:0] grp2_pins_r;

  wire [1:0] sel0 = trig_sel_r[`GRP0_SEL_LSB +: 2];
  wire [1:0] sel1 = trig_sel_r[`GRP1_SEL_LSB +: 2];
  wire [1:0] sel2 = trig_sel_r[`GRP2_SEL_LSB +: 2];
  wire [1:0] sel3 = trig_sel_r[`GRP3_SEL_LSB +: 2];
  wire same23 = (sel2 == sel3);
  wire same01 = (sel0 == sel1);

  // Address decode; word address index = paddr[9:2]
  wire [7:0] idx = paddr[9:2];
  wire addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire hit_ts = addr_ok && idx == `IDX_TRIG_SEL;
  wire hit_nh = addr_ok && idx == `IDX_NDE_HIGH;
  wire hit_nl = addr_ok && idx == `IDX_NDE_LOW;
  wire hit_he = addr_ok && idx == `IDX_ND_HIGH_EVEN;
  wire hit_le = addr_ok && idx == `IDX_ND_LOW_EVEN;
  wire hit_ho = addr_ok && idx == `IDX_ND_HIGH_ODD;
  wire hit_lo = addr_ok && idx == `IDX_ND_LOW_ODD;
  wire hit_ps = addr_ok && idx == `IDX_PORT_STATE;
  wire mapped = hit_ts | hit_nh | hit_nl | hit_he | hit_le | hit_ho | hit_lo | hit_ps;
  wire access = psel && penable;
  wire wr = access && pwrite && mapped;
  wire [7:0] wd = pwdata[7:0];
  wire wr_he = wr && hit_he;
  wire wr_ho = wr && hit_ho;
  wire wr_le = wr && hit_le;
  wire wr_lo = wr && hit_lo;

  // Layout-dependent views of the staged data
  wire [7:0] rd_he = same23 ? {nd_a4_upper_r, nd_high_r} : {nd_a4_upper_r, 4'hF};
  wire [7:0] rd_ho = same23 ? 8'hFF : {4'hF, nd_high_r};
  wire [7:0] rd_le = same01 ? nd_low_r : {nd_low_r[7:4], 4'hF};
  wire [7:0] rd_lo = same01 ? 8'hFF : {4'hF, nd_low_r[3:0]};
  wire [7:0] rd_byte =
    hit_ts ? trig_sel_r :
    hit_nh ? nde_high_r :
    hit_nl ? nde_low_r :
    hit_he ? rd_he :
    hit_ho ? rd_ho :
    hit_le ? rd_le :
    hit_lo ? rd_lo :
    hit_ps ? port_a_r : 8'h00;
  wire [31:0] rd_word = hit_ps ? {20'h00000, port_b_r, port_a_r} : {24'h000000, rd_byte};

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = (psel && !pwrite) ? rd_word : 32'h00000000;

  // Control registers are plain byte stores, written only in the access cycle
  always_comb begin
    trig_sel_nxt = trig_sel_r;
    if (wr && hit_ts) begin
      trig_sel_nxt = wd;
    end
  end

  always_comb begin
    nde_high_nxt = nde_high_r;
    if (wr && hit_nh) begin
      nde_high_nxt = wd;
    end
  end

  always_comb begin
    nde_low_nxt = nde_low_r;
    if (wr && hit_nl) begin
      nde_low_nxt = wd;
    end
  end

  // Upper nibble at the even high address is plain storage in both layouts
  always_comb begin
    nd_a4_upper_nxt = nd_a4_upper_r;
    if (wr_he) begin
      nd_a4_upper_nxt = wd[7:4];
    end
  end

  // A write to an address that the current layout does not map is dropped,
  // so software must set the trigger select before loading staged data
  always_comb begin
    nd_high_nxt = nd_high_r;
    if (wr_he && same23) begin
      nd_high_nxt = wd[3:0];
    end
    if (wr_ho && !same23) begin
      nd_high_nxt = wd[3:0];
    end
  end

  always_comb begin
    nd_low_nxt = nd_low_r;
    if (wr_le && same01) begin
      nd_low_nxt = wd;
    end
    if (wr_le && !same01) begin
      nd_low_nxt[7:4] = wd[7:4];
    end
    if (wr_lo && !same01) begin
      nd_low_nxt[3:0] = wd[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sel_r <= `RST_TRIG_SEL;
    end else begin
      trig_sel_r <= trig_sel_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nde_high_r <= `RST_NDE;
    end else begin
      nde_high_r <= nde_high_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nde_low_r <= `RST_NDE;
    end else begin
      nde_low_r <= nde_low_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nd_a4_upper_r <= `RST_ND_NIB;
    end else begin
      nd_a4_upper_r <= nd_a4_upper_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nd_high_r <= `RST_ND_NIB;
    end else begin
      nd_high_r <= nd_high_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nd_low_r <= `RST_ND;
    end else begin
      nd_low_r <= nd_low_nxt;
    end
  end

  // Group 0: pattern bits 3:0 on port A, fired by compare match A of its channel
  group_latch #(
    .W(4)
  ) u_grp0 (
    .pclk(pclk),
    .presetn(presetn),
    .sel(sel0),
    .match_a(timer_events.match_a),
    .staged(nd_low_r[3:0]),
    .enable(nde_low_r[3:0]),
    .pins_r(grp0_pins_r)
  );

  // Group 1: pattern bits 7:4 on port A
  group_latch #(
    .W(4)
  ) u_grp1 (
    .pclk(pclk),
    .presetn(presetn),
    .sel(sel1),
    .match_a(timer_events.match_a),
    .staged(nd_low_r[7:4]),
    .enable(nde_low_r[7:4]),
    .pins_r(grp1_pins_r)
  );

  // Group 2: pattern bits 11:8 on port B
  group_latch #(
    .W(4)
  ) u_grp2 (
    .pclk(pclk),
    .presetn(presetn),
    .sel(sel2),
    .match_a(timer_events.match_a),
    .staged(nd_high_r),
    .enable(nde_high_r[3:0]),
    .pins_r(grp2_pins_r)
  );

  // Group 3 owns no pins in this twelve-bit unit; its select only shapes the layout
  assign port_a_r = {grp1_pins_r, grp0_pins_r};
  assign port_b_r = grp2_pins_r;
  assign pins.port_a = port_a_r;
  assign pins.port_b = port_b_r;
endmodule

/* File: verification/timer_model.sv */
`timescale 1ns/100ps
module timer_model import pattern_pkg::*; (
  input wire logic pclk,
  input wire logic fire,
  input wire logic [1:0] ch,
  output timer_events_s ev
);
  always_ff @(posedge pclk) ev.match_a <= fire ? 4'h1 << ch : 4'h0;
endmodule

/* File: verification/po_trig_properties.sv */
`timescale 1ns/100ps
module po_trig_chk import pattern_pkg::*; (
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire timer_events_s timer_events,
  input wire pattern_pins_s pins
);
  logic [7:0] ts;
  wire [3:0] m = timer_events.match_a;
  wire rd = psel && penable && !pwrite;
  wire s23 = ts[7:6] == ts[5:4];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the trigger select, written on the access edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ts <= 8'hFF;
    else if (psel && penable && pwrite && paddr == 12'h284) ts <= pwdata[7:0];
  grp0_hold_a: assert property (!m[ts[1:0]] |=> $stable(pins.port_a[3:0])) else $error("g0 moved");
  grp1_hold_a: assert property (!m[ts[3:2]] |=> $stable(pins.port_a[7:4])) else $error("g1 moved");
  grp2_hold_a: assert property (!m[ts[5:4]] |=> $stable(pins.port_b)) else $error("g2 moved");
  grp3_hold_a: assert property (m == 4'h1 << ts[7:6] && ts[7:6] != ts[5:4] && ts[7:6] != ts[3:2] &&
    ts[7:6] != ts[1:0] |=> $stable(pins)) else $error("g3 moved pins");
  idle_hold_a: assert property (m == 4'h0 |=> $stable(pins)) else $error("pins moved");
  odd_ones_a: assert property (rd && paddr == 12'h298 && s23 |-> prdata[7:0] == 8'hFF) else $error("A6");
  even_ones_a: assert property (rd && paddr == 12'h290 && !s23 |-> prdata[3:0] == 4'hF) else $error("A4");
  low_ones_a: assert property (rd && paddr == 12'h29C && ts[3:2] == ts[1:0] |-> prdata[7:0] == 8'hFF)
    else $error("A7");
endmodule
bind pattern_output_trigger_select po_trig_chk u_po_trig_chk(.*);

/* File: verification/pattern_output_trigger_select_tb.sv */
`timescale 1ns/100ps
module pattern_output_trigger_select_tb;
  import pattern_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdata;
  logic [1:0] ch = 0;
  timer_events_s ev;
  pattern_pins_s pins;
  int bad_count = 0, cmp_count = 0;
  always #2 pclk = ~pclk;
  timer_model u_timer_model(.pclk, .fire, .ch, .ev);
  pattern_output_trigger_select u_pattern_output_trigger_select(.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_events(ev), .pins);
  task chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask
  task x(input logic [11:0] a, input logic [7:0] d, input logic w);
    @(posedge pclk);
    psel <= 1; paddr <= a; pwdata <= {24'h0, d}; pwrite <= w;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task r(input logic [11:0] a, input logic [7:0] e);
    x(a, 0, 0);
    chk(rdata, {24'h0, e});
  endtask
  task f(input logic [1:0] c, input logic [11:0] e);
    @(posedge pclk) fire <= 1;
    ch <= c;
    @(posedge pclk) fire <= 0;
    repeat (3) @(posedge pclk);
    chk({20'h0, pins}, {20'h0, e});
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20000 bad_count++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    r(12'h284, 8'hFF); r(12'h288, 0); r(12'h28C, 0);
    x(12'h100, 0, 0); chk(err, 1);
    $display("reset test done");
    x(12'h290, 8'h5A, 1); r(12'h290, 8'h5A); r(12'h298, 8'hFF);
    x(12'h294, 8'h3C, 1); r(12'h294, 8'h3C); r(12'h29C, 8'hFF);
    x(12'h284, 8'hE4, 1); x(12'h298, 8'h0B, 1); r(12'h298, 8'hFB); r(12'h290, 8'h5F);
    $display("layout test done");
    x(12'h288, 8'h0F, 1); x(12'h28C, 8'hFF, 1); x(12'h294, 8'h90, 1); x(12'h29C, 8'h06, 1);
    f(0, 12'h060); f(1, 12'h960); f(2, 12'h96B); f(3, 12'h96B);
    x(12'h288, 0, 1); x(12'h28C, 8'h0F, 1); x(12'h294, 8'h50, 1); x(12'h29C, 8'h01, 1);
    f(1, 12'h96B); f(0, 12'h91B); f(2, 12'h91B);
    x(12'h2C0, 0, 0); chk(rdata, 32'h00000B91);
    $display("trigger test done");
    conclude();
  end
endmodule
